/* logic/microport_pkg.sv */
package microport_pkg;

    localparam int INT_ADDR_W = 10;
    localparam int INT_DATA_W = 36;
    localparam int LANE_W     = 8;
    localparam int TOP_LANE_W = 4;

    localparam logic [2:0] SEL_LANE0    = 3'h0;
    localparam logic [2:0] SEL_LANE1    = 3'h1;
    localparam logic [2:0] SEL_LANE2    = 3'h2;
    localparam logic [2:0] SEL_LANE3    = 3'h3;
    localparam logic [2:0] SEL_LANE4    = 3'h4;
    localparam logic [2:0] SEL_LOW_ADDR = 3'h6;
    localparam logic [2:0] SEL_MODE     = 3'h7;

    localparam int INC_FIELD_LO = 6;
    localparam int INC_FIELD_HI = 7;
    localparam int HI_ADDR_LO   = 0;
    localparam int HI_ADDR_HI   = 1;

    localparam logic [1:0] INC_NONE  = 2'h0;
    localparam logic [1:0] INC_READ  = 2'h1;
    localparam logic [1:0] INC_WRITE = 2'h2;
    localparam logic [1:0] INC_ALL   = 2'h3;

    localparam logic [7:0] MODE_REG_RST = 8'h00;
    localparam logic [7:0] LOW_ADDR_RST = 8'h00;
    localparam logic [7:0] MODE_REG_IMPL = 8'hC3;

    localparam int FETCH_EXTRA = 1;

    typedef struct packed {
        logic                  we;
        logic                  re;
        logic [INT_ADDR_W-1:0] addr;
        logic [INT_DATA_W-1:0] wdata;
    } int_req_s;

endpackage

/* logic/lane_window.sv */
`timescale 1ns/1ns
module lane_window (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr_en,
    input  wire logic [2:0]  i_sel,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_load_en,
    input  wire logic [35:8] i_load_data,
    input  wire logic        i_step_rd,
    input  wire logic        i_step_wr,
    output logic      [35:8] o_lanes,
    output logic      [9:0]  o_addr,
    output logic      [7:0]  o_rdata
);
    import microport_pkg::*;

    logic [7:0] lane [1:4];
    logic [7:0] internal_addr_low_reg;
    logic [7:0] addr_mode_reg;
    logic [1:0] inc_field;
    logic       do_step;

    function automatic logic hits(input logic [2:0] sel, input logic [2:0] want);
        hits = (sel == want);
    endfunction

    genvar g;
    generate
        for (g = 1; g <= 4; g++) begin : g_lane
            logic [7:0] load_byte;
            // The top lane holds only a nibble, so its load must not reach past bit 35.
            if (g == 4) begin : g_top
                assign load_byte = {4'h0, i_load_data[35:32]};
            end else begin : g_full
                assign load_byte = i_load_data[g*8 +: 8];
            end
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    lane[g] <= 8'h00;
                end else if (i_load_en) begin
                    lane[g] <= load_byte;
                end else if (i_wr_en && hits(i_sel, 3'(g))) begin
                    lane[g] <= i_wdata;
                end
            end
        end
    endgenerate

    assign inc_field = addr_mode_reg[INC_FIELD_HI:INC_FIELD_LO];
    assign do_step   = (i_step_rd && inc_field[0]) || (i_step_wr && inc_field[1]);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            internal_addr_low_reg <= LOW_ADDR_RST;
            addr_mode_reg         <= MODE_REG_RST;
        end else if (i_wr_en && hits(i_sel, SEL_LOW_ADDR)) begin
            internal_addr_low_reg <= i_wdata;
        end else if (i_wr_en && hits(i_sel, SEL_MODE)) begin
            addr_mode_reg <= i_wdata & MODE_REG_IMPL;
        end else if (do_step) begin
            // The carry out of the low byte runs into the high bits.
            {addr_mode_reg[HI_ADDR_HI:HI_ADDR_LO], internal_addr_low_reg} <= o_addr + 10'h001;
        end
    end

    assign o_addr  = {addr_mode_reg[HI_ADDR_HI:HI_ADDR_LO], internal_addr_low_reg};
    assign o_lanes = {lane[4][TOP_LANE_W-1:0], lane[3], lane[2], lane[1]};

    always_comb begin
        unique case (i_sel)
            SEL_LANE1:    o_rdata = lane[1];
            SEL_LANE2:    o_rdata = lane[2];
            SEL_LANE3:    o_rdata = lane[3];
            SEL_LANE4:    o_rdata = {4'h0, lane[4][TOP_LANE_W-1:0]};
            SEL_LOW_ADDR: o_rdata = internal_addr_low_reg;
            SEL_MODE:     o_rdata = addr_mode_reg;
            default:      o_rdata = 8'h00;
        endcase
    end
endmodule

/* logic/microport_indirect_access.sv */
`timescale 1ns/1ns
module microport_indirect_access (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_mode,
    input  wire logic                   i_cs_n,
    input  wire logic                   i_rd_n,
    input  wire logic                   i_wr_n,
    input  wire logic [2:0]             i_addr,
    input  wire logic [7:0]             i_data,
    input  wire logic                   i_serial_busy,
    input  wire logic [35:0]            i_int_rdata,
    output logic      [7:0]             o_data,
    output logic                        o_data_oe_n,
    output logic                        o_rdy,
    output logic                        o_transfer_ack_n,
    output microport_pkg::int_req_s     o_int
);
    import microport_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_HOLD  = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_XFER  = 5'b01000,
        ST_DONE  = 5'b10000
    } port_state_e;

    port_state_e state;
    port_state_e next_state;

    logic        req_seen;
    logic        req_read;
    logic        strobe_low;
    logic        act_read;
    logic [2:0]  act_sel;
    logic [7:0]  act_wdata;
    logic        act_mode1;
    logic        done;

    logic        win_wr_en;
    logic        win_load_en;
    logic        step_rd;
    logic        step_wr;
    logic [35:8] win_lanes;
    logic [9:0]  win_addr;
    logic [7:0]  win_rdata;

    // Strobe meaning depends on the mode pin.
    assign strobe_low = i_mode ? !i_rd_n : (!i_rd_n || !i_wr_n);
    assign req_read   = i_mode ? i_wr_n : !i_rd_n;
    assign req_seen   = !i_cs_n && strobe_low;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (req_seen) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Serial owns the internal space; the host simply waits.
                if (!i_serial_busy) begin
                    if (act_read && act_sel == SEL_LANE0) begin
                        next_state = ST_FETCH;
                    end else begin
                        next_state = ST_XFER;
                    end
                end
            end
            ST_FETCH: begin
                next_state = ST_XFER;
            end
            ST_XFER: begin
                next_state = ST_DONE;
            end
            ST_DONE: begin
                if (i_cs_n) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The access is captured once at edge N so later pin wiggles cannot change it.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            act_read  <= 1'b0;
            act_sel   <= 3'h0;
            act_wdata <= 8'h00;
            act_mode1 <= 1'b0;
        end else if (state == ST_IDLE && req_seen) begin
            act_read  <= req_read;
            act_sel   <= i_addr;
            act_wdata <= i_data;
            act_mode1 <= i_mode;
        end
    end

    assign win_wr_en   = (state == ST_HOLD) && !i_serial_busy && !act_read;
    assign win_load_en = (state == ST_FETCH);
    assign step_rd     = win_load_en;
    assign step_wr     = win_wr_en && act_sel == SEL_LANE0;

    lane_window u_window (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_wr_en     (win_wr_en),
        .i_sel       (act_sel),
        .i_wdata     (act_wdata),
        .i_load_en   (win_load_en),
        .i_load_data (i_int_rdata[35:8]),
        .i_step_rd   (step_rd),
        .i_step_wr   (step_wr),
        .o_lanes     (win_lanes),
        .o_addr      (win_addr),
        .o_rdata     (win_rdata)
    );

    // Internal strobes are one-cycle pulses; the address is taken before any step.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int <= '0;
        end else begin
            o_int.we <= 1'b0;
            o_int.re <= 1'b0;
            if (state == ST_HOLD && !i_serial_busy && act_sel == SEL_LANE0) begin
                o_int.addr <= win_addr;
                if (act_read) begin
                    o_int.re <= 1'b1;
                end else begin
                    o_int.we    <= 1'b1;
                    o_int.wdata <= {win_lanes, act_wdata};
                end
            end
        end
    end

    // Lane zero read data is the fetched low byte, never a stored copy.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data      <= 8'h00;
            o_data_oe_n <= 1'b1;
        end else if (state == ST_FETCH) begin
            o_data <= i_int_rdata[7:0];
        end else if (state == ST_XFER && act_read) begin
            if (act_sel != SEL_LANE0) begin
                o_data <= win_rdata;
            end
            o_data_oe_n <= 1'b0;
        end else if (state == ST_DONE && i_cs_n) begin
            o_data_oe_n <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done <= 1'b0;
        end else if (state == ST_XFER) begin
            done <= 1'b1;
        end else if (state == ST_DONE && i_cs_n) begin
            done <= 1'b0;
        end
    end

    // Ready must fall without waiting for a clock, so it is the one output built
    // from pins; the released state itself comes from the done flag.
    assign o_rdy = !(i_serial_busy || (req_seen && !i_mode && !done));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_transfer_ack_n <= 1'b1;
        end else if (state == ST_XFER && act_mode1) begin
            o_transfer_ack_n <= 1'b0;
        end else if (i_cs_n || i_rd_n) begin
            o_transfer_ack_n <= 1'b1;
        end
    end
endmodule

/* bench/microport_props.sv */
`timescale 1ns/1ns
module microport_props (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire logic                    i_mode,
    input wire logic                    i_cs_n,
    input wire logic                    i_rd_n,
    input wire logic                    i_wr_n,
    input wire logic [2:0]              i_addr,
    input wire logic                    i_serial_busy,
    input wire logic                    o_rdy,
    input wire logic                    o_data_oe_n,
    input wire logic                    o_transfer_ack_n,
    input wire microport_pkg::int_req_s o_int
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Start of an access from idle with the serial port quiet for two edges.
    sequence s_start(m, r, w, z);
        $fell(i_cs_n) && i_mode == m && i_rd_n == r && i_wr_n == w &&
        (i_addr == 3'h0) == z && !i_serial_busy ##1 !i_serial_busy;
    endsequence

    a_m0_rdy_drop: assert property ($fell(i_cs_n) && !i_mode && !(i_rd_n && i_wr_n) |-> !o_rdy)
        else $error("ready not low at access start");
    a_m0_wr_time: assert property (s_start(0, 1, 0, 0) |-> ##1 !o_rdy ##1 o_rdy)
        else $error("mode 0 write ready timing");
    a_m0_rd_lane0: assert property (s_start(0, 0, 1, 1) |-> ##1 !o_rdy ##1 !o_rdy ##1 o_rdy)
        else $error("mode 0 lane 0 read ready timing");
    a_m0_rd_other: assert property (s_start(0, 0, 1, 0) |-> ##1 !o_rdy ##1 o_rdy)
        else $error("mode 0 read ready timing");
    a_m1_rd_lane0: assert property (s_start(1, 0, 1, 1) |->
        ##1 o_transfer_ack_n ##1 o_transfer_ack_n ##1 !o_transfer_ack_n)
        else $error("mode 1 lane 0 read acknowledge timing");
    a_m1_wr_ack: assert property (s_start(1, 0, 0, 0) |->
        ##1 o_transfer_ack_n ##1 !o_transfer_ack_n)
        else $error("mode 1 write acknowledge timing");
    a_ack_hold: assert property (!o_transfer_ack_n && !i_cs_n && !i_rd_n |=> !o_transfer_ack_n)
        else $error("acknowledge dropped early");
    a_ack_release: assert property (!o_transfer_ack_n && i_cs_n |=> o_transfer_ack_n)
        else $error("acknowledge not released");
    a_busy_hold: assert property (i_serial_busy && !i_mode |-> !o_rdy)
        else $error("ready high while serial port busy");
    a_re_pulse: assert property (o_int.re |=> !o_int.re)
        else $error("internal read pulse too long");
    a_we_pulse: assert property (o_int.we |=> !o_int.we)
        else $error("internal write pulse too long");
    a_oe_read: assert property (s_start(0, 0, 1, 0) |-> ##2 !o_data_oe_n)
        else $error("read data not driven with ready");
    a_oe_release: assert property (!o_data_oe_n && i_cs_n |=> o_data_oe_n)
        else $error("data bus not released after chip select");
endmodule

/* bench/microport_host_model.sv */
`timescale 1ns/1ns
module microport_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rdy,
    input  wire logic       i_ack_n,
    input  wire logic [7:0] i_rdata,
    output logic            o_mode,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic      [2:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial begin
        o_mode = 1'b0;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 3'h0;
        o_wdata = 8'h00;
    end

    // Pins move on the falling edge, so the port clock always samples settled levels.
    task automatic access(input logic m, input logic wr, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q, output int lat,
                          input logic hold = 1'b0);
        @(negedge i_clk);
        o_mode = m;
        o_cs_n = 1'b0;
        o_rd_n = !m && wr;
        o_wr_n = !wr;
        o_addr = a;
        o_wdata = d;
        lat = 0;
        @(negedge i_clk);
        while ((m ? i_ack_n : !i_rdy) && lat < 40) begin
            lat++;
            @(negedge i_clk);
        end
        q = i_rdata;
        o_cs_n = 1'b1;
        if (!hold) begin
            o_rd_n = 1'b1;
            o_wr_n = 1'b1;
        end
        o_wdata = ~d;
        @(negedge i_clk);
    endtask
endmodule

/* bench/microport_indirect_access_tb_top.sv */
`timescale 1ns/1ns
module microport_indirect_access_tb_top;
    import microport_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_serial_busy = 1'b0;
    logic [35:0] i_int_rdata;
    logic        mode, cs_n, rd_n, wr_n, o_data_oe_n, o_rdy, o_transfer_ack_n;
    logic [2:0]  addr;
    logic [7:0]  wdata, o_data, q;
    int_req_s    o_int;
    logic [35:0] mem [0:1023];
    logic [9:0]  last_wa, last_ra;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          lat;

    always #4 i_clk = ~i_clk;

    microport_host_model host (.i_clk(i_clk), .i_rdy(o_rdy), .i_ack_n(o_transfer_ack_n),
        .i_rdata(o_data), .o_mode(mode), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_addr(addr), .o_wdata(wdata));

    microport_indirect_access dut (.i_clk(i_clk), .i_rst(i_rst), .i_mode(mode), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata),
        .i_serial_busy(i_serial_busy), .i_int_rdata(i_int_rdata), .o_data(o_data),
        .o_data_oe_n(o_data_oe_n), .o_rdy(o_rdy), .o_transfer_ack_n(o_transfer_ack_n),
        .o_int(o_int));

    // The port takes the fetched word at the edge that ends its read pulse, so the
    // internal space must answer within the cycle in which the pulse stands.
    assign i_int_rdata = mem[o_int.addr];

    always @(posedge i_clk) begin
        if (o_int.we) begin
            mem[o_int.addr] <= o_int.wdata;
            last_wa <= o_int.addr;
        end
        if (o_int.re) begin
            last_ra <= o_int.addr;
        end
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic m, input logic [2:0] a, input logic [7:0] d);
        host.access(m, 1'b1, a, d, q, lat);
        chk(36'(lat), 36'h2);
        chk(36'(o_transfer_ack_n), 36'h1);
    endtask

    task automatic rd(input logic m, input logic [2:0] a, input logic [7:0] e, input int el);
        host.access(m, 1'b0, a, 8'h00, q, lat);
        chk(36'(q), 36'(e));
        chk(36'(lat), 36'(el));
        chk(36'(o_transfer_ack_n), 36'h1);
    endtask

    task automatic t_reset();
        chk(36'(o_data_oe_n), 36'h1);
        rd(0, SEL_MODE, MODE_REG_RST, 2);
        rd(0, SEL_LOW_ADDR, LOW_ADDR_RST, 2);
        rd(0, 3'h5, 8'h00, 2);
        $display("test reset done");
    endtask

    task automatic t_block(input logic m);
        logic [9:0] ia;
        ia = {m ? 2'h2 : 2'h1, 8'h23};
        wr(m, SEL_MODE, {6'h00, ia[9:8]});
        wr(m, SEL_LOW_ADDR, 8'h23);
        for (int i = 4; i > 0; i--) wr(m, 3'(i), 8'(i * 17));
        wr(m, SEL_LANE0, 8'h11);
        chk(mem[ia], 36'h4_3322_1111);
        // Spoil a lane so the reads below can only pass through the reload.
        wr(m, SEL_LANE1, 8'hEE);
        rd(m, SEL_LANE0, 8'h11, 3);
        chk(36'(last_ra), 36'(ia));
        // Lane 4 holds only a nibble, the port reads the rest as zero.
        for (int i = 1; i < 5; i++) rd(m, 3'(i), i == 4 ? 8'h04 : 8'(i * 17), 2);
        rd(m, SEL_MODE, {6'h00, ia[9:8]}, 2);
        $display("test block mode %0d done", m);
    endtask

    task automatic t_inc();
        for (int c = 0; c < 4; c++) begin
            wr(1, SEL_MODE, {2'(c), 6'h00});
            rd(1, SEL_MODE, {2'(c), 6'h00}, 2);
            wr(1, SEL_LOW_ADDR, 8'hFF);
            wr(1, SEL_LANE0, 8'h5A);
            chk(36'(last_wa), 36'h0FF);
            host.access(1, 1'b0, SEL_LANE0, 8'h00, q, lat);
            chk(36'(last_ra), 36'(10'h0FF + c / 2));
            wr(1, SEL_LANE0, 8'hA5);
            chk(36'(last_wa), 36'(10'h0FF + c / 2 + c % 2));
        end
        $display("test increment done");
    endtask

    task automatic t_busy();
        for (int m = 0; m < 2; m++) begin
            i_serial_busy = 1'b1;
            fork
                host.access(1'(m), 1'b1, SEL_LANE1, 8'h66, q, lat);
                begin
                    repeat (4) @(negedge i_clk);
                    i_serial_busy = 1'b0;
                end
            join
            chk(36'(lat), 36'h4);
        end
        $display("test serial priority done");
    endtask

    task automatic t_hold();
        host.access(1, 1'b1, SEL_LANE1, 8'h5C, q, lat, 1'b1);
        chk(36'(lat), 36'h2);
        host.access(1, 1'b1, SEL_LANE2, 8'hC5, q, lat);
        chk(36'(lat), 36'h2);
        rd(1, SEL_LANE1, 8'h5C, 2);
        rd(1, SEL_LANE2, 8'hC5, 2);
        $display("test held strobe done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        t_reset();
        t_block(1'b0);
        t_block(1'b1);
        t_inc();
        t_busy();
        t_hold();
        tally_and_finish();
    end
endmodule

bind microport_indirect_access microport_props props (.i_clk(i_clk), .i_rst(i_rst),
    .i_mode(i_mode), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr),
    .i_serial_busy(i_serial_busy), .o_rdy(o_rdy), .o_transfer_ack_n(o_transfer_ack_n),
    .o_data_oe_n(o_data_oe_n), .o_int(o_int));
